// >>> shared/clk_net_pkg.sv
// Functional notes
// [R01] Each quadrant has eight regional nets fed by pins, PLL outputs or logic.
// [R02] One pin or PLL output can drive one line in two adjacent quadrants.
// [R03] Core logic routing may also drive a dual-regional clock.
// [R04] Top/bottom pins and enhanced PLL outputs drive horizontal dual-regional clocks.
// [R05] Left/right pins and fast PLL outputs drive vertical dual-regional clocks.
// [R06] Corner PLLs never source a dual-regional clock.
// [R07] Each quadrant combines 16 global and 8 regional lines into 24 resources.
// [R08] Each cluster picks three of six row clocks for its registers.
// [R09] Each I/O clock region gets 8 clocks chosen from 24 quadrant resources.
// [R10] Every global net, regional net and PLL output pin has a control block.
// [R11] Global source select is dynamic from user logic or fixed by configuration.
// [R12] Dynamic global choice is between two configured candidates of any kind.
// [R13] Static selection may choose any multiplexer input.
// [R14] Regional and PLL output pin selection is configuration only.
// [R15] Only top and bottom dedicated pins feed the regional selector.
// [R16] The PLL output pin carries either an internal signal or its control output.
// [R17] A powered-down net delivers no clock edges at all.
// [R18] Nets power down statically by configuration; unused nets default powered down.
// [R19] User logic enables and disables nets and pins, applied synchronously.
// [R20] Gating acts on the net only and never touches PLL operation.
// [R21] Four enhanced and four fast PLLs serve as clock sources.
// [R22] Enable and source changes apply only while the clock is low.
// [R23] User logic holds select and enable stable and synchronous to the clock.
package clk_net_pkg;
  localparam int NQ = 4;
  localparam int NL = 8;
  localparam int NG = 16;
  localparam int NR = NQ * NL;
  localparam int NP = 8;
  localparam int NPIN = 12;
  localparam int NCORE = 4;
  localparam int NRES = NG + NL;
  localparam int NROW = 6;
  localparam int NCLU = 3;
  localparam int NIO = 8;
  // Source index map of the 32-input selector
  localparam logic [4:0] SRC_PIN_LR = 5'h00;
  localparam logic [4:0] SRC_PIN_TB = 5'h08;
  localparam logic [4:0] SRC_PLL_ENH = 5'h0C;
  localparam logic [4:0] SRC_PLL_FAST = 5'h14;
  localparam logic [4:0] SRC_PLL_CORNER = 5'h18;
  localparam logic [4:0] SRC_CORE = 5'h1C;
  // Register byte offsets
  localparam logic [9:0] OFF_GCFG = 10'h000;
  localparam logic [9:0] OFF_RCFG = 10'h040;
  localparam logic [9:0] OFF_PCFG = 10'h0C0;
  localparam logic [9:0] OFF_ROW = 10'h0E0;
  localparam logic [9:0] OFF_CLU = 10'h0F0;
  localparam logic [9:0] OFF_IOLO = 10'h100;
  localparam logic [9:0] OFF_IOHI = 10'h110;
  localparam logic [9:0] OFF_GON = 10'h120;
  localparam logic [9:0] OFF_RON = 10'h124;
  localparam logic [9:0] OFF_ILL = 10'h128;
  localparam logic [9:0] OFF_PON = 10'h12C;
  localparam logic [9:0] OFF_END = 10'h130;

  typedef struct packed {
    logic       pd;
    logic       dyn;
    logic [4:0] cand1;
    logic [4:0] cand0;
    logic [4:0] sel;
  } gcfg_type;

  typedef struct packed {
    logic       horiz;
    logic       dual;
    logic       pd;
    logic [4:0] sel;
  } rcfg_type;

  typedef struct packed {
    logic       use_int;
    logic       pd;
    logic [4:0] sel;
  } pcfg_type;

  typedef struct packed {
    logic [NIO-1:0][4:0]  io;
    logic [NCLU-1:0][2:0] clu;
    logic [NROW-1:0][4:0] row;
  } qcfg_type;

  // Every net and PLL pin powered down, quadrant selections cleared, until software configures it
  localparam gcfg_type GCFG_RST = 17'h10000;
  localparam rcfg_type RCFG_RST = 8'h20;
  localparam pcfg_type PCFG_RST = 7'h20;
  localparam qcfg_type QCFG_RST = '0;
endpackage

// >>> logic/clock_network_control.sv
`timescale 1ns/1ps
module clk_ctrl_cell (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Sources and selection
  input  wire logic [31:0] src,
  input  wire logic [4:0]  sel_a,
  input  wire logic [4:0]  sel_b,
  input  wire logic        pick_b,
  // Gating
  input  wire logic        pd,
  input  wire logic        en,
  input  wire logic        legal,
  // Net
  output logic             out_r,
  output logic             on_r
);
  logic [4:0] cur_sel_r;
  logic [4:0] tgt;
  logic       want;
  logic       quiet;

  assign tgt = pick_b ? sel_b : sel_a;
  assign want = en & ~pd & legal; // see [R18]
  // Old and new clock both low, so no runt pulse leaves the cell
  assign quiet = (~on_r | ~src[cur_sel_r]) & ~src[tgt]; // see [R22]

  always_ff @(posedge mclk) begin
    if (reset) begin
      cur_sel_r <= 5'h00;
      on_r      <= 1'b0;
    end else if (quiet) begin
      cur_sel_r <= tgt; // see [R13]
      on_r      <= want; // see [R19]
    end
  end

  // A source stuck high delays every change until it falls
  always_ff @(posedge mclk) begin
    if (reset) begin
      out_r <= 1'b0;
    end else begin
      out_r <= on_r & src[cur_sel_r]; // see [R17]
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  chk_off_quiet: assert property (!on_r |=> !out_r) // see [R17]
    else $error("disabled net produced a clock edge");
  chk_apply_low: assert property (($changed(cur_sel_r) || $changed(on_r)) |-> !out_r) // see [R22]
    else $error("select or enable changed while net was high");
  chk_enable_gate: assert property ($rose(on_r) |-> $past(en && !pd && legal)) // see [R19]
    else $error("net enabled without request or while powered down");
endmodule // clk_ctrl_cell

module clock_network_control #(
  parameter int unsigned ADDR_W = 10
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata_r,
  // Clock sources
  input  wire logic [11:0]       dedicated_input_pin_n,
  input  wire logic [7:0]        pll_counter_output_zero,
  input  wire logic [7:0]        pll_counter_output_one,
  input  wire logic [3:0]        core_clk,
  // Dynamic control from user logic
  input  wire logic [15:0]       gsel_dyn,
  input  wire logic [15:0]       g_en,
  input  wire logic [31:0]       r_en,
  input  wire logic [7:0]        p_en,
  input  wire logic [7:0]        pin_int,
  // Clock outputs
  output logic [15:0]            device_wide_net_r,
  output logic [31:0]            rnet_r,
  output logic [7:0]             pll_pin_r,
  output logic [11:0]            cluster_clk_r,
  output logic [31:0]            io_clk_r
);
  if (ADDR_W < 10) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  clk_net_pkg::gcfg_type gcfg [clk_net_pkg::NG];
  clk_net_pkg::rcfg_type rcfg [clk_net_pkg::NR];
  clk_net_pkg::pcfg_type pcfg [clk_net_pkg::NP];
  clk_net_pkg::qcfg_type qcfg [clk_net_pkg::NQ];
  logic [31:0] src;
  logic [15:0] g_on;
  logic [31:0] r_on;
  logic [31:0] r_legal;
  logic [7:0]  p_on;
  logic [7:0]  p_out;
  logic [31:0] rd_mux;
  logic [9:0]  a;

  assign a = addr[9:0];

  function automatic logic reg_ok(input logic [4:0] s);
    return s >= clk_net_pkg::SRC_PIN_TB; // see [R15]
  endfunction

  function automatic logic dual_ok(input logic [4:0] s, input logic horiz);
    logic core;
    core = s >= clk_net_pkg::SRC_CORE; // see [R03]
    if (horiz) begin
      return core | (s >= clk_net_pkg::SRC_PIN_TB && s < clk_net_pkg::SRC_PLL_FAST); // see [R04]
    end
    // Corner fast PLLs sit between the side PLLs and core routing
    return core | s < clk_net_pkg::SRC_PIN_TB
         | (s >= clk_net_pkg::SRC_PLL_FAST && s < clk_net_pkg::SRC_PLL_CORNER); // see [R05] see [R06]
  endfunction

  function automatic logic pick24(input logic [23:0] res, input logic [4:0] idx);
    return (idx < 5'(clk_net_pkg::NRES)) ? res[idx] : 1'b0;
  endfunction

  // Sources are only observed; nothing flows back toward the PLLs
  assign src[11:0]  = dedicated_input_pin_n;
  assign src[31:28] = core_clk;
  for (genvar p = 0; p < clk_net_pkg::NP; p++) begin : g_src
    assign src[12 + 2 * p] = pll_counter_output_zero[p]; // see [R21] see [R20]
    assign src[13 + 2 * p] = pll_counter_output_one[p];
  end

  // Global nets: static choice or dynamic pick of two candidates
  for (genvar g = 0; g < clk_net_pkg::NG; g++) begin : g_glob
    logic dyn;
    assign dyn = gcfg[g].dyn;
    clk_ctrl_cell u_cell ( // see [R10]
      .mclk   (mclk),
      .reset  (reset),
      .src    (src),
      .sel_a  (dyn ? gcfg[g].cand0 : gcfg[g].sel), // see [R12]
      .sel_b  (gcfg[g].cand1),
      .pick_b (dyn & gsel_dyn[g]), // see [R11]
      .pd     (gcfg[g].pd),
      .en     (g_en[g]),
      .legal  (1'b1),
      .out_r  (device_wide_net_r[g]),
      .on_r   (g_on[g])
    );
  end

  // Regional nets, eight per quadrant, with dual-regional pairing
  for (genvar n = 0; n < clk_net_pkg::NR; n++) begin : g_reg
    clk_net_pkg::rcfg_type effc;
    always_comb begin
      effc = rcfg[n];
      if (!rcfg[n].dual) begin
        if (rcfg[n ^ 8].dual && rcfg[n ^ 8].horiz) begin
          effc = rcfg[n ^ 8]; // see [R02]
        end else if (rcfg[n ^ 16].dual && !rcfg[n ^ 16].horiz) begin
          effc = rcfg[n ^ 16];
        end
      end
    end
    assign r_legal[n] = effc.dual ? dual_ok(effc.sel, effc.horiz) : reg_ok(effc.sel);
    clk_ctrl_cell u_cell ( // see [R01]
      .mclk   (mclk),
      .reset  (reset),
      .src    (src),
      .sel_a  (effc.sel),
      .sel_b  (5'h00),
      .pick_b (1'b0), // see [R14]
      .pd     (effc.pd),
      .en     (r_en[n]),
      .legal  (r_legal[n]),
      .out_r  (rnet_r[n]),
      .on_r   (r_on[n])
    );

    chk_reg_pins: assert property (@(posedge mclk) disable iff (reset) // see [R15]
      (r_legal[n] && !effc.dual) |-> effc.sel >= clk_net_pkg::SRC_PIN_TB)
      else $error("side pin accepted by a regional selector");
    chk_corner_dual: assert property (@(posedge mclk) disable iff (reset) // see [R06]
      (r_legal[n] && effc.dual) |-> !(effc.sel >= clk_net_pkg::SRC_PLL_CORNER && effc.sel < clk_net_pkg::SRC_CORE))
      else $error("corner PLL accepted for a dual-regional clock");
  end

  // PLL external output pins
  for (genvar p = 0; p < clk_net_pkg::NP; p++) begin : g_pout
    clk_ctrl_cell u_cell (
      .mclk   (mclk),
      .reset  (reset),
      .src    (src),
      .sel_a  (pcfg[p].sel),
      .sel_b  (5'h00),
      .pick_b (1'b0), // see [R14]
      .pd     (pcfg[p].pd),
      .en     (p_en[p]), // see [R19]
      .legal  (1'b1),
      .out_r  (p_out[p]),
      .on_r   (p_on[p])
    );

    always_ff @(posedge mclk) begin
      if (reset) begin
        pll_pin_r[p] <= 1'b0;
      end else begin
        pll_pin_r[p] <= pcfg[p].use_int ? pin_int[p] : p_out[p]; // see [R16]
      end
    end

    chk_pin_mux: assert property (@(posedge mclk) disable iff (reset) // see [R16]
      ##1 pll_pin_r[p] == ($past(pcfg[p].use_int) ? $past(pin_int[p]) : $past(p_out[p])))
      else $error("PLL output pin shows the wrong signal");
  end

  // Quadrant row, cluster and I/O clock selection
  for (genvar q = 0; q < clk_net_pkg::NQ; q++) begin : g_quad
    logic [23:0]               res;
    logic [clk_net_pkg::NROW-1:0] row;
    assign res = {rnet_r[q * clk_net_pkg::NL +: clk_net_pkg::NL], device_wide_net_r}; // see [R07]
    for (genvar j = 0; j < clk_net_pkg::NROW; j++) begin : g_row
      assign row[j] = pick24(res, qcfg[q].row[j]);
    end
    for (genvar i = 0; i < clk_net_pkg::NCLU; i++) begin : g_clu
      always_ff @(posedge mclk) begin
        if (reset) begin
          cluster_clk_r[q * clk_net_pkg::NCLU + i] <= 1'b0;
        end else begin
          cluster_clk_r[q * clk_net_pkg::NCLU + i] <= (qcfg[q].clu[i] < 3'(clk_net_pkg::NROW))
                                                      ? row[qcfg[q].clu[i]] : 1'b0; // see [R08]
        end
      end
    end
    for (genvar k = 0; k < clk_net_pkg::NIO; k++) begin : g_io
      always_ff @(posedge mclk) begin
        if (reset) begin
          io_clk_r[q * clk_net_pkg::NIO + k] <= 1'b0;
        end else begin
          io_clk_r[q * clk_net_pkg::NIO + k] <= pick24(res, qcfg[q].io[k]); // see [R09]
        end
      end
    end
  end

  // Register writes; unused nets come out of reset powered down
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < clk_net_pkg::NG; i++) begin
        gcfg[i] <= clk_net_pkg::GCFG_RST; // see [R18]
      end
      for (int i = 0; i < clk_net_pkg::NR; i++) begin
        rcfg[i] <= clk_net_pkg::RCFG_RST;
      end
      for (int i = 0; i < clk_net_pkg::NP; i++) begin
        pcfg[i] <= clk_net_pkg::PCFG_RST;
      end
      for (int i = 0; i < clk_net_pkg::NQ; i++) begin
        qcfg[i] <= clk_net_pkg::QCFG_RST;
      end
    end else if (wr) begin
      if (a < clk_net_pkg::OFF_RCFG) begin
        gcfg[a[5:2]] <= wdata[16:0];
      end else if (a < clk_net_pkg::OFF_PCFG) begin
        rcfg[5'(a[9:2] - 8'h10)] <= wdata[7:0];
      end else if (a < clk_net_pkg::OFF_ROW) begin
        pcfg[a[4:2]] <= wdata[6:0];
      end else if (a < clk_net_pkg::OFF_CLU) begin
        qcfg[a[3:2]].row <= wdata[29:0];
      end else if (a < clk_net_pkg::OFF_IOLO) begin
        qcfg[a[3:2]].clu <= wdata[8:0];
      end else if (a < clk_net_pkg::OFF_IOHI) begin
        qcfg[a[3:2]].io[3:0] <= wdata[19:0];
      end else if (a < clk_net_pkg::OFF_GON) begin
        qcfg[a[3:2]].io[7:4] <= wdata[19:0];
      end
    end
  end

  // Read decode; status words show which nets actually run and which regional selections are illegal
  always_comb begin
    rd_mux = 32'h00000000;
    if (a < clk_net_pkg::OFF_RCFG) begin
      rd_mux = 32'(gcfg[a[5:2]]);
    end else if (a < clk_net_pkg::OFF_PCFG) begin
      rd_mux = 32'(rcfg[5'(a[9:2] - 8'h10)]);
    end else if (a < clk_net_pkg::OFF_ROW) begin
      rd_mux = 32'(pcfg[a[4:2]]);
    end else if (a < clk_net_pkg::OFF_CLU) begin
      rd_mux = 32'(qcfg[a[3:2]].row);
    end else if (a < clk_net_pkg::OFF_IOLO) begin
      rd_mux = 32'(qcfg[a[3:2]].clu);
    end else if (a < clk_net_pkg::OFF_IOHI) begin
      rd_mux = 32'(qcfg[a[3:2]].io[3:0]);
    end else if (a < clk_net_pkg::OFF_GON) begin
      rd_mux = 32'(qcfg[a[3:2]].io[7:4]);
    end else if (a == clk_net_pkg::OFF_GON) begin
      rd_mux = 32'(g_on);
    end else if (a == clk_net_pkg::OFF_RON) begin
      rd_mux = r_on;
    end else if (a == clk_net_pkg::OFF_ILL) begin
      rd_mux = ~r_legal;
    end else if (a == clk_net_pkg::OFF_PON) begin
      rd_mux = 32'(p_on);
    end
    if (addr >= ADDR_W'(clk_net_pkg::OFF_END) || addr[1:0] != 2'h0) begin
      rd_mux = 32'h00000000;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rd ? rd_mux : 32'h00000000;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  chk_rdata_idle: assert property (!rd |=> rdata_r == 32'h00000000)
    else $error("read data present without a read strobe");
  chk_reset_down: assert property ($fell(reset) |-> (g_on == 16'h0000 && r_on == 32'h0 && p_on == 8'h00)) // see [R18]
    else $error("net running straight after reset");
endmodule // clock_network_control

// >>> tb/user_logic_model.sv
`timescale 1ns/1ps
module user_logic_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Requests from the bench
  input  wire logic [15:0] g_en_req,
  input  wire logic [31:0] r_en_req,
  input  wire logic [7:0]  p_en_req,
  input  wire logic [15:0] gsel_req,
  // Clock sources
  output logic [11:0]      dedicated_input_pin_n,
  output logic [7:0]       pll_counter_output_zero,
  output logic [7:0]       pll_counter_output_one,
  output logic [3:0]       core_clk,
  // Dynamic control
  output logic [15:0]      gsel_dyn,
  output logic [15:0]      g_en,
  output logic [31:0]      r_en,
  output logic [7:0]       p_en
);
  logic [31:0] lfsr_r;

  // Irregular sources, so a wrong pick shows up within a few cycles
  always_ff @(posedge mclk) begin
    if (reset) begin
      lfsr_r <= 32'h1;
    end else begin
      lfsr_r <= {lfsr_r[30:0], 1'b0} ^ (lfsr_r[31] ? 32'h04C11DB7 : 32'h0);
    end
  end

  assign dedicated_input_pin_n = lfsr_r[11:0];
  assign core_clk = lfsr_r[31:28];
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pll_counter_output_zero[p] = lfsr_r[12 + 2 * p];
      pll_counter_output_one[p] = lfsr_r[13 + 2 * p];
    end
  end

  // Control changes only at an edge and then holds a full cycle at least
  always_ff @(posedge mclk) begin
    if (reset) begin
      gsel_dyn <= 16'h0000;
      g_en     <= 16'h0000;
      r_en     <= 32'h0000_0000;
      p_en     <= 8'h00;
    end else begin
      gsel_dyn <= gsel_req;
      g_en     <= g_en_req;
      r_en     <= r_en_req;
      p_en     <= p_en_req;
    end
  end
endmodule // user_logic_model

// >>> tb/test_clock_network_control.sv
`timescale 1ns/1ps
module test_clock_network_control;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata_r;
  logic [11:0] dedicated_input_pin_n;
  logic [7:0]  pll_counter_output_zero;
  logic [7:0]  pll_counter_output_one;
  logic [3:0]  core_clk;
  logic [15:0] gsel_dyn;
  logic [15:0] g_en;
  logic [31:0] r_en;
  logic [7:0]  p_en;
  logic [7:0]  pin_int = 8'h00;
  logic [15:0] device_wide_net_r;
  logic [31:0] rnet_r;
  logic [7:0]  pll_pin_r;
  logic [11:0] cluster_clk_r;
  logic [31:0] io_clk_r;
  logic [15:0] g_en_req = 16'h0;
  logic [31:0] r_en_req = 32'h0;
  logic [7:0]  p_en_req = 8'h0;
  logic [15:0] gsel_req = 16'h0;
  logic [31:0] src_all;
  logic [31:0] src_h1;
  logic [31:0] src_h2;
  logic [31:0] v;
  int          err_count = 0;
  int          samples_checked = 0;
  int          seed = 32'h2ab1;
  int          rsel [7] = '{2, 10, 12, 21, 29, 25, 20};
  int          rmode [7] = '{0, 0, 1, 2, 1, 2, 1};
  int          rok [7] = '{0, 1, 1, 1, 1, 0, 0};

  always #12.5 mclk = ~mclk;

  clock_network_control i_clock_network_control (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .dedicated_input_pin_n(dedicated_input_pin_n),
    .pll_counter_output_zero(pll_counter_output_zero), .pll_counter_output_one(pll_counter_output_one),
    .core_clk(core_clk), .gsel_dyn(gsel_dyn), .g_en(g_en), .r_en(r_en), .p_en(p_en), .pin_int(pin_int),
    .device_wide_net_r(device_wide_net_r), .rnet_r(rnet_r), .pll_pin_r(pll_pin_r),
    .cluster_clk_r(cluster_clk_r), .io_clk_r(io_clk_r));

  user_logic_model i_user_logic_model (.mclk(mclk), .reset(reset), .g_en_req(g_en_req), .r_en_req(r_en_req),
    .p_en_req(p_en_req), .gsel_req(gsel_req), .dedicated_input_pin_n(dedicated_input_pin_n),
    .pll_counter_output_zero(pll_counter_output_zero), .pll_counter_output_one(pll_counter_output_one),
    .core_clk(core_clk), .gsel_dyn(gsel_dyn), .g_en(g_en), .r_en(r_en), .p_en(p_en));

  always_comb begin
    src_all = {core_clk, 16'h0, dedicated_input_pin_n};
    for (int p = 0; p < 8; p++) begin
      src_all[12 + 2 * p] = pll_counter_output_zero[p];
      src_all[13 + 2 * p] = pll_counter_output_one[p];
    end
  end

  always @(posedge mclk) begin
    src_h1 <= src_all;
    src_h2 <= src_h1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [9:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    d = rdata_r;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    rd_reg(a, d);
    check(what, d, e);
  endtask

  // Polls a status bit, bounded, then compares it
  task automatic wait_bit(input logic [9:0] a, input int b, input logic e, input string what);
    logic [31:0] d;
    for (int i = 0; i < 40; i++) begin
      rd_reg(a, d);
      if (d[b] === e) break;
    end
    check(what, {31'h0, d[b]}, {31'h0, e});
  endtask

  function automatic logic out_bit(input int kind, input int idx);
    case (kind)
      0: return device_wide_net_r[idx];
      1: return rnet_r[idx];
      2: return pll_pin_r[idx];
      3: return cluster_clk_r[idx];
      default: return io_clk_r[idx];
    endcase
  endfunction

  // Latency 0 means the net must stay dark, 3 means the pin shows pin_int
  function automatic logic exp_bit(input int lat, input int s);
    case (lat)
      0: return 1'b0;
      1: return src_h1[s];
      2: return src_h2[s];
      default: return pin_int[s];
    endcase
  endfunction

  task automatic track(input string what, input int kind, input int idx, input int lat, input int s);
    repeat (12) begin
      @(negedge mclk);
      check(what, {31'h0, out_bit(kind, idx)}, {31'h0, exp_bit(lat, s)});
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #750000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(clk_net_pkg::OFF_GCFG, 32'h10000, "gcfg reset");
    rd_chk(clk_net_pkg::OFF_RCFG, 32'h20, "rcfg reset");
    rd_chk(clk_net_pkg::OFF_PCFG, 32'h20, "pcfg reset");
    rd_chk(clk_net_pkg::OFF_GON, 32'h0, "global on");
    check("nets off", {16'h0, device_wide_net_r}, 32'h0);
    $display("test reset done");
    for (int g = 1; g < 16; g++) begin
      v = $random(seed) & 32'h1FFFF;
      wr_reg(clk_net_pkg::OFF_GCFG + 10'(4 * g), v);
      rd_chk(clk_net_pkg::OFF_GCFG + 10'(4 * g), v, "gcfg readback");
    end
    wr_reg(clk_net_pkg::OFF_END, 32'hFFFFFFFF);
    rd_chk(clk_net_pkg::OFF_END, 32'h0, "unmapped");
    rd_chk(10'h002, 32'h0, "unaligned");
    wr_reg(clk_net_pkg::OFF_GON, 32'hFFFFFFFF);
    rd_chk(clk_net_pkg::OFF_GON, 32'h0, "status read only");
    $display("test registers done");
    g_en_req <= 16'hFFFF;
    for (int k = 0; k < 32; k++) begin
      wr_reg(clk_net_pkg::OFF_GCFG + 10'(4 * (k % 16)), 32'(k));
      if (k < 16) wait_bit(clk_net_pkg::OFF_GON, k, 1'b1, "global on");
      repeat (40) @(posedge mclk);
      track("global static", 0, k % 16, 1, k);
    end
    $display("test static select done");
    wr_reg(clk_net_pkg::OFF_GCFG + 10'h00C, 32'h0000B8A0);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      @(posedge mclk);
      gsel_req <= {12'h0, v[0], 3'h0};
      repeat (40) @(posedge mclk);
      track("global dynamic", 0, 3, 1, v[0] ? 14 : 5);
    end
    @(posedge mclk);
    g_en_req <= 16'hFFF7;
    wait_bit(clk_net_pkg::OFF_GON, 3, 1'b0, "global off");
    track("global gated", 0, 3, 0, 0);
    wr_reg(clk_net_pkg::OFF_GCFG + 10'h008, 32'h00010007);
    wait_bit(clk_net_pkg::OFF_GON, 2, 1'b0, "global pd");
    track("global powered down", 0, 2, 0, 0);
    $display("test dynamic control done");
    for (int q = 0; q < 4; q++) begin
      wr_reg(clk_net_pkg::OFF_ROW + 10'(4 * q), 32'h1);
      wr_reg(clk_net_pkg::OFF_CLU + 10'(4 * q), 32'h1);
      wr_reg(clk_net_pkg::OFF_IOLO + 10'(4 * q), 32'h1);
      repeat (3) @(posedge mclk);
      track("cluster clock", 3, 3 * q, 2, 16);
      track("io clock", 4, 8 * q, 2, 17);
    end
    $display("test row clocks done");
    @(posedge mclk);
    r_en_req <= 32'hFFFFFFFF;
    for (int i = 0; i < 7; i++) begin
      wr_reg(clk_net_pkg::OFF_RCFG + 10'(4 * i), 32'(rsel[i] | ((rmode[i] != 0) << 6) | ((rmode[i] == 1) << 7)));
      if (rok[i] == 1) wait_bit(clk_net_pkg::OFF_RON, i, 1'b1, "regional on");
      else wait_bit(clk_net_pkg::OFF_ILL, i, 1'b1, "regional illegal");
      repeat (40) @(posedge mclk);
      track("regional", 1, i, rok[i], rsel[i]);
      if (rok[i] == 1 && rmode[i] != 0) track("dual partner", 1, i ^ (rmode[i] == 1 ? 8 : 16), 1, rsel[i]);
    end
    $display("test regional done");
    @(posedge mclk);
    p_en_req <= 8'hFF;
    wr_reg(clk_net_pkg::OFF_PCFG + 10'h004, 32'h0000000D);
    wait_bit(clk_net_pkg::OFF_PON, 1, 1'b1, "pll pin on");
    repeat (40) @(posedge mclk);
    track("pll pin", 2, 1, 2, 13);
    wr_reg(clk_net_pkg::OFF_PCFG + 10'h004, 32'h0000004D);
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk);
      pin_int <= (j == 0) ? 8'h02 : 8'h00;
      repeat (4) @(posedge mclk);
      track("pll pin internal", 2, 1, 3, 1);
    end
    wr_reg(clk_net_pkg::OFF_PCFG + 10'h004, 32'h0000000D);
    @(posedge mclk);
    p_en_req <= 8'hFD;
    wait_bit(clk_net_pkg::OFF_PON, 1, 1'b0, "pll pin off");
    track("pll pin gated", 2, 1, 0, 0);
    $display("test pll pin done");
    give_verdict();
  end
endmodule // test_clock_network_control
